// file: sslp_pkg.sv
// Shared constants and types for the synthesizer serial load port.
// Assumes one system clock; all frequencies are counted in reference oscillator edges.
package sslp_pkg;

  // Shift register and latch widths.
  localparam int SR_W = 20;
  localparam int DIV_W = 14;
  localparam int FUNC_W = 6;

  // Shift register positions: bit 0 holds the last bit received.
  localparam int SR_DIV_MSB_POS = 6;
  localparam int SR_DIV_LSB_POS = 19;
  localparam int SR_FUNC_MSB_POS = 5;

  // Index of the band select bit inside the six function bits (output bit 18).
  localparam int BAND_IDX = 3;

  // Reset values of the holding latches and the shift register.
  localparam logic [DIV_W-1:0] DIV_RST = 14'h0000;
  localparam logic [FUNC_W-1:0] FUNC_RST = 6'h00;
  localparam logic [SR_W-1:0] SR_RST = 20'h00000;

  // Reference chain frequencies in hertz.
  localparam int REF_OSC_HZ = 4000000;
  localparam int CTRL_CLK_HZ = 500000;
  localparam int FM_REF_HZ = 12500;
  localparam int AM_REF_HZ = 500;
  localparam int TOD_HZ = 50;

  // Number of reference chain taps and their half periods in oscillator edges.
  localparam int NUM_TAPS = 4;
  localparam int TAP_CTRL = 0;
  localparam int TAP_FM = 1;
  localparam int TAP_AM = 2;
  localparam int TAP_TOD = 3;
  localparam int TAP_HALF [NUM_TAPS] = '{
    REF_OSC_HZ / (2 * CTRL_CLK_HZ),
    REF_OSC_HZ / (2 * FM_REF_HZ),
    REF_OSC_HZ / (2 * AM_REF_HZ),
    REF_OSC_HZ / (2 * TOD_HZ)
  };
  localparam int TAP_CNT_W = 16;

  // Serial entry states, Gray coded along address then data.
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR0 = 3'h1,
    ST_ADDR1 = 3'h3,
    ST_SHIFT = 3'h2,
    ST_IGNORE = 3'h6
  } sslp_state_t;

  // Contents of the holding latches.
  typedef struct packed {
    logic [DIV_W-1:0] divide;
    logic [FUNC_W-1:0] funcBits;
  } sslp_latch_t;

  // The three wires from the controller.
  typedef struct packed {
    logic enable;
    logic sclk;
    logic sdata;
  } sslp_serial_t;

endpackage

// file: sslp_ref_div.sv
// Square wave divider on a tick stream, one tap of the reference chain.
// Assumes the tick is a one-cycle pulse in the clk_sys domain.
`timescale 1ns/100ps
module sslp_ref_div #(
  parameter int HALF = 4
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Tick to divide.
  input wire logic tick,
  // Divided square wave.
  output logic divOut
);

  // Edge counter within the current half period.
  logic [sslp_pkg::TAP_CNT_W-1:0] cnt;
  logic [sslp_pkg::TAP_CNT_W-1:0] next_cnt;
  logic next_divOut;

  // Count ticks and flip the output every half period.
  always_comb
  begin
    next_cnt = cnt;
    next_divOut = divOut;
    if (tick)
    begin
      if (cnt >= sslp_pkg::TAP_CNT_W'(HALF - 1))
      begin
        next_cnt = '0;
        next_divOut = ~divOut;
      end
      else
      begin
        next_cnt = cnt + 1'b1;
      end
    end
  end

  // Register the divider state.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      cnt <= '0;
      divOut <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      divOut <= next_divOut;
    end
  end

  // The output flips exactly when a half period of ticks is complete.
  a_tap_half_period: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (tick && cnt == sslp_pkg::TAP_CNT_W'(HALF - 1)) |=> (divOut != $past(divOut)))
    else $error("Reference tap did not flip at end of half period.");

  a_tap_steady: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !tick |=> $stable(divOut) && $stable(cnt))
    else $error("Reference tap changed without a tick.");

endmodule

// file: sslp_top.sv
// Serial load port of a radio synthesizer: three-wire entry, latches, divider, references.
// Assumes enable, serial clock, data and oscillator inputs are synchronous to clk_sys.
// Operation
// - Serial entry only while enable is low.
// - One data bit per serial clock rise.
// - First two bits after enable fall address.
// - Wrong address ignores data, latches unchanged.
// - Address one-one shifts following bits in.
// - Only the last twenty bits are kept.
// - Enable rise stops entry, loads latches only after address one-one.
// - Last six bits drive outputs, bit18 band.
// - Divide value LSB first, fourteen bits.
// - Programmable divider divides by value plus one.
// - Band bit picks input and reference.
// - Oscillator divided down to controller clock.
// - Chain also makes fifty hertz timing output.
`timescale 1ns/100ps
module sslp_top (
  // System clock and synchronous reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Three-wire serial link from the controller.
  input wire sslp_pkg::sslp_serial_t serialIn,
  // Reference oscillator and local oscillator inputs after prescaling.
  input wire logic refOsc,
  input wire logic fmIn,
  input wire logic amIn,
  // Holding latch contents and open collector function outputs.
  output sslp_pkg::sslp_latch_t latch,
  output logic [sslp_pkg::FUNC_W-1:0] funcOut,
  output logic [sslp_pkg::FUNC_W-1:0] funcOe,
  // Divider and reference outputs.
  output logic divPulse,
  output logic refSel,
  output logic ctrlClk,
  output logic todClk
);

  // Serial entry state and sampled wire history.
  sslp_pkg::sslp_state_t state;
  sslp_pkg::sslp_state_t next_state;
  logic enPrev;
  logic sclkPrev;
  logic [sslp_pkg::SR_W-1:0] shiftReg;
  logic [sslp_pkg::SR_W-1:0] next_shiftReg;
  sslp_pkg::sslp_latch_t next_latch;
  // Latch image built from the shift register.
  sslp_pkg::sslp_latch_t newLatch;
  // Edge strobes of the serial wires.
  logic enFall;
  logic sclkRise;

  // Programmable divider state.
  logic [sslp_pkg::DIV_W-1:0] divCnt;
  logic [sslp_pkg::DIV_W-1:0] next_divCnt;
  logic next_divPulse;
  logic loPrev;
  logic loSel;
  logic loTick;
  logic refPrev;
  logic refTick;
  logic [sslp_pkg::NUM_TAPS-1:0] taps;
  logic next_refSel;
  logic band;

  assign enFall = enPrev && !serialIn.enable;
  assign sclkRise = serialIn.sclk && !sclkPrev;
  assign band = latch.funcBits[sslp_pkg::BAND_IDX];

  // Map the shift register onto the latch layout; divide value arrives LSB first.
  genvar gi;
  generate
    for (gi = 0; gi < sslp_pkg::DIV_W; gi++)
    begin : g_div_map
      assign newLatch.divide[gi] = shiftReg[sslp_pkg::SR_DIV_LSB_POS - gi];
    end
    for (gi = 0; gi < sslp_pkg::FUNC_W; gi++)
    begin : g_func_map
      assign newLatch.funcBits[gi] = shiftReg[sslp_pkg::SR_FUNC_MSB_POS - gi];
    end
  endgenerate

  // Serial entry: address check, shifting and latching on enable rise.
  always_comb
  begin
    next_state = state;
    next_shiftReg = shiftReg;
    next_latch = latch;
    unique case (state)
      sslp_pkg::ST_IDLE:
      begin
        // Clock edges while enable is high are not entry; only its fall starts a transfer.
        if (enFall)
        begin
          next_state = sslp_pkg::ST_ADDR0;
        end
      end
      default:
      begin
        if (serialIn.enable)
        begin
          // Enable rose: entry stops, and only an addressed transfer loads.
          next_state = sslp_pkg::ST_IDLE;
          if (state == sslp_pkg::ST_SHIFT)
          begin
            next_latch = newLatch;
          end
        end
        else if (sclkRise)
        begin
          if (state == sslp_pkg::ST_ADDR0)
          begin
            next_state = serialIn.sdata ? sslp_pkg::ST_ADDR1 : sslp_pkg::ST_IGNORE;
          end
          else if (state == sslp_pkg::ST_ADDR1)
          begin
            next_state = serialIn.sdata ? sslp_pkg::ST_SHIFT : sslp_pkg::ST_IGNORE;
          end
          else if (state == sslp_pkg::ST_SHIFT)
          begin
            // Oldest bit falls off the top, so only the last twenty remain.
            next_shiftReg = {shiftReg[sslp_pkg::SR_W-2:0], serialIn.sdata};
          end
        end
      end
    endcase
  end

  // Register serial entry state and wire history.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      state <= sslp_pkg::ST_IDLE;
      enPrev <= 1'b1;
      sclkPrev <= 1'b0;
      shiftReg <= sslp_pkg::SR_RST;
      latch <= '{divide: sslp_pkg::DIV_RST, funcBits: sslp_pkg::FUNC_RST};
    end
    else
    begin
      state <= next_state;
      enPrev <= serialIn.enable;
      sclkPrev <= serialIn.sclk;
      shiftReg <= next_shiftReg;
      latch <= next_latch;
    end
  end

  // Open collector outputs pull low while their latched bit is zero.
  assign funcOut = '0;
  assign funcOe = ~latch.funcBits;

  // Band select picks the local oscillator input feeding the divider.
  assign loSel = band ? fmIn : amIn;
  assign loTick = loSel && !loPrev;
  assign refTick = refOsc && !refPrev;

  // Programmable divider: one pulse every divide plus one input edges.
  always_comb
  begin
    next_divCnt = divCnt;
    next_divPulse = 1'b0;
    if (loTick)
    begin
      if (divCnt >= latch.divide)
      begin
        next_divCnt = '0;
        next_divPulse = 1'b1;
      end
      else
      begin
        next_divCnt = divCnt + 1'b1;
      end
    end
    next_refSel = band ? taps[sslp_pkg::TAP_FM] : taps[sslp_pkg::TAP_AM];
  end

  // Register divider, edge history and selected reference.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      divCnt <= '0;
      divPulse <= 1'b0;
      loPrev <= 1'b0;
      refPrev <= 1'b0;
      refSel <= 1'b0;
    end
    else
    begin
      divCnt <= next_divCnt;
      divPulse <= next_divPulse;
      loPrev <= loSel;
      refPrev <= refOsc;
      refSel <= next_refSel;
    end
  end

  // Reference chain taps, each an independent divider of the oscillator edges.
  generate
    for (gi = 0; gi < sslp_pkg::NUM_TAPS; gi++)
    begin : g_taps
      sslp_ref_div #(
        .HALF(sslp_pkg::TAP_HALF[gi])
      ) u_tap (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .tick(refTick),
        .divOut(taps[gi])
      );
    end
  endgenerate

  assign ctrlClk = taps[sslp_pkg::TAP_CTRL];
  assign todClk = taps[sslp_pkg::TAP_TOD];

  // Checks on serial entry, latching and the divider.
  a_high_blocks_entry: assert property (@(posedge clk_sys) disable iff (!rst_n)
    serialIn.enable |=> $stable(shiftReg))
    else $error("Shift register moved while enable was high.");

  a_one_bit_shift: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state == sslp_pkg::ST_SHIFT && !serialIn.enable && sclkRise)
    |=> shiftReg == {$past(shiftReg[sslp_pkg::SR_W-2:0]), $past(serialIn.sdata)})
    else $error("Serial clock rise did not shift exactly one bit.");

  a_addr_zero_ignores: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state inside {sslp_pkg::ST_ADDR0, sslp_pkg::ST_ADDR1} && !serialIn.enable && sclkRise && !serialIn.sdata)
    |=> state == sslp_pkg::ST_IGNORE)
    else $error("Zero address bit did not reject the transfer.");

  a_bad_addr_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state == sslp_pkg::ST_IGNORE && serialIn.enable) |=> $stable(latch) && state == sslp_pkg::ST_IDLE)
    else $error("Unaddressed transfer changed the latches.");

  a_latch_on_rise: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state == sslp_pkg::ST_SHIFT && serialIn.enable) |=> latch == $past(newLatch))
    else $error("Latches not loaded from shift register at enable rise.");

  a_latch_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !(state == sslp_pkg::ST_SHIFT && serialIn.enable) |=> $stable(latch))
    else $error("Latches changed outside an addressed enable rise.");

  a_bit_order: assert property (@(posedge clk_sys) disable iff (!rst_n)
    newLatch.divide[0] == shiftReg[19] && newLatch.divide[13] == shiftReg[6]
    && newLatch.funcBits[5] == shiftReg[0] && newLatch.funcBits[3] == shiftReg[2])
    else $error("Latch bit mapping is wrong.");

  a_div_wrap: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (loTick && divCnt == latch.divide) |=> divPulse && divCnt == '0)
    else $error("Divider did not wrap after value plus one edges.");

  a_div_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (loTick && divCnt < latch.divide) |=> !divPulse && divCnt == $past(divCnt) + 1'b1)
    else $error("Divider pulsed early.");

  a_band_ref: assert property (@(posedge clk_sys) disable iff (!rst_n)
    1'b1 |=> refSel == ($past(band) ? $past(taps[sslp_pkg::TAP_FM]) : $past(taps[sslp_pkg::TAP_AM])))
    else $error("Reference not chosen by band select.");

  // Main scenarios.
  c_addressed_load: cover property (@(posedge clk_sys) disable iff (!rst_n)
    state == sslp_pkg::ST_SHIFT && serialIn.enable);
  c_rejected: cover property (@(posedge clk_sys) disable iff (!rst_n)
    state == sslp_pkg::ST_IGNORE && serialIn.enable);
  c_early_rise: cover property (@(posedge clk_sys) disable iff (!rst_n)
    state == sslp_pkg::ST_ADDR1 && serialIn.enable);
  c_div_pulse: cover property (@(posedge clk_sys) disable iff (!rst_n) divPulse && band);

endmodule

// file: sslp_ctrl_model.sv
// Behavioural model of the serial radio controller on the far side of the load port.
// Assumes the bench calls its tasks; all wires change on the falling edge of clk_sys.
`timescale 1ns/100ps
module sslp_ctrl_model (
  // System clock used to pace the wires.
  input wire logic clk_sys,
  // Three wires towards the device.
  output sslp_pkg::sslp_serial_t serialOut
);
  // Idle link: enable high, serial clock parked low.
  initial serialOut = 3'h4;

  // One bit: data settles a cycle ahead of the clock rise and is held until the clock falls.
  task automatic bit_out(input logic b);
    @(negedge clk_sys);
    serialOut.sdata = b;
    @(negedge clk_sys);
    serialOut.sclk = 1'b1;
    @(negedge clk_sys);
    serialOut.sclk = 1'b0;
    // The data line is no longer held, so it shows the inverse of the last bit.
    serialOut.sdata = ~b;
  endtask

  // One transfer: na address bits from a (high bit first), then n data bits of d, last bit d[0].
  task automatic send(input logic [1:0] a, input int na, input int n, input logic [31:0] d);
    @(negedge clk_sys);
    // The clock is already low and stays low for three cycles past the enable fall.
    serialOut.enable = 1'b0;
    @(negedge clk_sys);
    for (int i = 0; i < na; i++)
      bit_out(a[1-i]);
    for (int i = n - 1; i >= 0; i--)
      bit_out(d[i]);
    @(negedge clk_sys);
    serialOut.enable = 1'b1;
    // Give the device two edges to move the shift register into the latches.
    repeat (2) @(negedge clk_sys);
  endtask
endmodule

// file: tb_synth_serial_load_port.sv
// Self-checking bench for the synthesizer serial load port.
// Assumes the controller model drives the link and the bench drives oscillator inputs.
`timescale 1ns/100ps
module tb_synth_serial_load_port;
  // Clock, reset and oscillator stimulus.
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic refOsc = 1'b0;
  logic fmIn = 1'b0;
  logic amIn = 1'b0;
  int tick = 0;
  // Device outputs.
  sslp_pkg::sslp_serial_t serialWire;
  sslp_pkg::sslp_latch_t latch;
  logic [5:0] funcOut;
  logic [5:0] funcOe;
  logic divPulse;
  logic refSel;
  logic ctrlClk;
  logic todClk;
  // Score keeping and the expected shift register, bit 0 last received.
  int numErrors = 0;
  int checks = 0;
  logic [19:0] expSr = sslp_pkg::SR_RST;
  logic [19:0] expLatch = 20'h00000;

  // Clock of 40 ns period.
  always #20 clk_sys = ~clk_sys;

  // Oscillator and LO inputs: refOsc and fmIn rise every 4 cycles, amIn every 6.
  always @(negedge clk_sys)
  begin
    tick <= tick + 1;
    refOsc <= tick[1];
    fmIn <= tick[1];
    amIn <= (tick % 6) >= 3;
  end

  sslp_ctrl_model sslp_ctrl_model_inst (
    .clk_sys(clk_sys),
    .serialOut(serialWire)
  );

  sslp_top sslp_top_inst (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .serialIn(serialWire),
    .refOsc(refOsc),
    .fmIn(fmIn),
    .amIn(amIn),
    .latch(latch),
    .funcOut(funcOut),
    .funcOe(funcOe),
    .divPulse(divPulse),
    .refSel(refSel),
    .ctrlClk(ctrlClk),
    .todClk(todClk)
  );

  // Prints the verdict and ends the run.
  task automatic stop_test;
    if (numErrors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Compares one value and reports a mismatch at once.
  task automatic check(input logic [19:0] seen, input logic [19:0] expv);
    checks++;
    if (seen !== expv)
    begin
      numErrors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, expv);
    end
  endtask

  // Picks a periodic output: 0 controller clock, 1 reference, 2 divider pulse.
  function automatic logic pick(input int sel);
    return sel == 0 ? ctrlClk : (sel == 1 ? refSel : divPulse);
  endfunction

  // Waits for the next low to high change of the picked output.
  task automatic wait_rise(input int sel);
    logic p;
    p = pick(sel);
    @(negedge clk_sys);
    while (!(p === 1'b0 && pick(sel) === 1'b1))
    begin
      p = pick(sel);
      @(negedge clk_sys);
    end
  endtask

  // Measures one period of the picked output in clock cycles.
  task automatic period(input int sel, input int expv);
    time t0;
    wait_rise(sel);
    t0 = $time;
    wait_rise(sel);
    check(20'(($time - t0) / 40), 20'(expv));
  endtask

  // Runs one transfer, tracks the expected shift register and judges the latches.
  task automatic load(input logic [1:0] a, input int na, input int n, input logic [31:0] d);
    logic [19:0] r;
    sslp_ctrl_model_inst.send(a, na, n, d);
    if (a == 2'h3 && na == 2)
    begin
      for (int i = 0; i < n; i++)
        expSr = {expSr[18:0], d[n-1-i]};
      for (int i = 0; i < 20; i++)
        r[i] = expSr[19-i];
      expLatch = {r[13:0], r[19:14]};
    end
    check(20'(latch), expLatch);
    check(20'(funcOe), {14'h0000, ~expLatch[5:0]});
    check(20'(funcOut), 20'h00000);
  endtask

  // Latches and open collector enables after reset.
  task automatic test_reset;
    check(20'(latch), 20'h00000);
    check(20'(funcOe), 20'h0003F);
  endtask

  // Free running taps: controller clock and the band low reference.
  task automatic test_refs;
    period(0, sslp_pkg::TAP_HALF[sslp_pkg::TAP_CTRL] * 8);
    period(1, sslp_pkg::TAP_HALF[sslp_pkg::TAP_AM] * 8);
    // Far fewer oscillator rises than one timing half period have passed, so it is still low.
    check(20'(todClk), 20'h00000);
  endtask

  // Long addressed transfer: only the last twenty bits land, LSB of the divide first.
  task automatic test_full;
    load(2'h3, 2, 24, 32'h00E5A3C6);
    load(2'h3, 2, 20, 32'h0005A9E3);
  endtask

  // Every wrong address leaves the latches alone.
  task automatic test_addr;
    for (int a = 0; a < 3; a++)
      load(2'(a), 2, 20, 32'h0001234C ^ 32'(a));
  endtask

  // Enable returns high before the address is complete.
  task automatic test_early;
    load(2'h3, 1, 0, 32'h0);
    load(2'h3, 0, 0, 32'h0);
  endtask

  // Short transfer: older contents move up, address bits are not data.
  task automatic test_short;
    load(2'h3, 2, 5, 32'h00000015);
  endtask

  // Clock pulses while enable is high must not shift anything.
  task automatic test_idle;
    repeat (4) sslp_ctrl_model_inst.bit_out(1'b1);
    load(2'h3, 2, 1, 32'h0);
  endtask

  // Divide by N plus one on the LO picked by the band bit, and the matching reference.
  task automatic test_band;
    load(2'h3, 2, 20, 32'h000A0004);
    wait_rise(2);
    period(2, 6 * 4);
    wait_rise(1);
    period(1, sslp_pkg::TAP_HALF[sslp_pkg::TAP_FM] * 8);
    load(2'h3, 2, 20, 32'h000A0000);
    wait_rise(2);
    period(2, 6 * 6);
  endtask

  // Main sequence.
  initial
  begin
    repeat (6) @(negedge clk_sys);
    rst_n = 1'b1;
    test_reset;
    test_refs;
    test_full;
    test_addr;
    test_early;
    test_short;
    test_idle;
    test_band;
    stop_test;
  end

  // Watchdog sized about a third above the longest expected run.
  initial
  begin
    #(70000 * 40);
    numErrors++;
    stop_test;
  end
endmodule
